// ---- logic/adc_channel_enable_control.v ----
// Converter control: busy, done, error, channel and enable registers
`include "adc_ctrl_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module adc_channel_enable_control #(
	parameter CLK_NS = `CLK_NS,
	parameter HOLD_NS = `HOLD_NS,
	parameter BIT_NS = `BIT_NS
) (
	input wire core_clk, // 125 MHz clock
	input wire rstn, // Synchronous reset, active low
	input wire init, // System init strobe
	input wire io_pause, // I/O pause, device field valid
	input wire [5:0] dev_sel, // Device select field
	input wire [2:0] op_code, // Operation field
	input wire time_pulse_three, // Single-cycle TP3 strobe
	input wire [11:0] data_in, // Accumulator onto data bus
	input wire [11:0] result_in, // Converted result bits 0-11
	input wire last_shift, // Last bit checked strobe
	input wire external_conversion_start, // External start pin
	output reg [11:0] data_out_ff, // Data bus drive value
	output reg data_oe_n_ff, // Data bus drive, active low
	output reg skip_ff, // Skip request
	output reg irq_ff, // Interrupt request
	output reg busy_ff, // Conversion in progress
	output reg done_ff, // Conversion done flag
	output reg timing_err_ff, // Timing error flag
	output reg [3:0] channel_select_ff, // Multiplexer channel
	output reg [3:0] enables_ff, // Enable register
	output reg mode_hold_ff, // Mode select, 1 is hold
	output reg bit_clk_ff, // Bit-timing clock pulse
	output reg [9:0] shift_pos_ff, // Bit-position shift register
	output reg eoc_ff // End-of-conversion pulse
);
	localparam integer HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
	localparam integer BIT_CYC = (BIT_NS + CLK_NS - 1) / CLK_NS;
	localparam ST_IDLE = 3'b001;
	localparam ST_HOLD = 3'b010;
	localparam ST_BITS = 3'b100;

	wire ext_lvl;
	reg ext_d_ff;
	reg [2:0] state_ff;
	reg [2:0] nxt_state;
	reg [12:0] cnt_ff;
	reg [12:0] nxt_cnt;
	wire sel;
	wire clr_all;
	wire common_clear;
	wire op_start;
	wire op_ld_en;
	wire op_ld_ch;
	wire op_rd_st;
	wire op_rd_bf;
	wire ext_go;
	wire start;
	wire [3:0] next_channel;

	sync3 u_ext_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.din(external_conversion_start),
		.dout_ff(ext_lvl)
	);

	assign sel = io_pause && (dev_sel == `DEV_CODE);
	assign clr_all = sel && time_pulse_three && (op_code == `OP_CLEAR_ALL);
	assign common_clear = init || clr_all;
	// Start, load-enable, load-channel and clear-all act on the TP3 strobe only
	assign op_start = sel && time_pulse_three && (op_code == `OP_START);
	assign op_ld_en = sel && time_pulse_three && (op_code == `OP_LOAD_EN);
	assign op_ld_ch = sel && time_pulse_three && (op_code == `OP_LOAD_CHAN);
	assign op_rd_st = sel && (op_code == `OP_READ_STAT);
	assign op_rd_bf = sel && (op_code == `OP_READ_BUF);
	// Rising edge of filtered external start, gated by its enable
	assign ext_go = ext_lvl && !ext_d_ff && enables_ff[`EN_EXT];
	assign start = (op_start || ext_go) && !busy_ff;
	assign next_channel = channel_select_ff + 4'h1;

	always @* begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				nxt_cnt = 13'h0000;
				if (start) begin
					nxt_state = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Hold settles before first bit
				if (cnt_ff == HOLD_CYC[12:0] - 13'h0001) begin
					nxt_cnt = 13'h0000;
					nxt_state = ST_BITS;
				end else begin
					nxt_cnt = cnt_ff + 13'h0001;
				end
			end
			ST_BITS: begin
				if (cnt_ff == BIT_CYC[12:0] - 13'h0001) begin
					nxt_cnt = 13'h0000;
				end else begin
					nxt_cnt = cnt_ff + 13'h0001;
				end
				if (last_shift || (bit_clk_ff && shift_pos_ff[0])) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state = ST_IDLE;
				nxt_cnt = 13'h0000;
			end
		endcase
		if (common_clear) begin
			nxt_state = ST_IDLE;
			nxt_cnt = 13'h0000;
		end
	end

	always @(posedge core_clk) begin
		if (!rstn) begin
			state_ff <= ST_IDLE;
			cnt_ff <= 13'h0000;
			ext_d_ff <= 1'b0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			timing_err_ff <= 1'b0;
			channel_select_ff <= 4'h0;
			enables_ff <= 4'h0;
			mode_hold_ff <= 1'b0;
			bit_clk_ff <= 1'b0;
			shift_pos_ff <= 10'h000;
			eoc_ff <= 1'b0;
			irq_ff <= 1'b0;
			skip_ff <= 1'b0;
			data_out_ff <= 12'h000;
			data_oe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			ext_d_ff <= ext_lvl;
			eoc_ff <= 1'b0;
			bit_clk_ff <= 1'b0;
			// Busy: set by start, cleared by end of conversion or clear
			if (common_clear) begin
				busy_ff <= 1'b0;
				shift_pos_ff <= 10'h000;
				mode_hold_ff <= 1'b0;
			end else if (start) begin
				busy_ff <= 1'b1;
				mode_hold_ff <= 1'b1;
				shift_pos_ff <= `SHIFT_FIRST;
			end else if (state_ff == ST_BITS && nxt_state == ST_IDLE) begin
				busy_ff <= 1'b0;
				mode_hold_ff <= 1'b0;
				shift_pos_ff <= 10'h000;
				eoc_ff <= 1'b1;
			end else if (state_ff == ST_BITS &&
				cnt_ff == BIT_CYC[12:0] - 13'h0001) begin
				bit_clk_ff <= 1'b1;
				shift_pos_ff <= {1'b0, shift_pos_ff[9:1]};
			end
			// Done: set by conversion end wins over start clear
			if (common_clear) begin
				done_ff <= 1'b0;
			end else if (state_ff == ST_BITS && nxt_state == ST_IDLE) begin
				done_ff <= 1'b1;
			end else if (start) begin
				done_ff <= 1'b0;
			end
			if (common_clear) begin
				timing_err_ff <= 1'b0;
			end else if (busy_ff && (op_ld_ch || ext_go ||
				(op_rd_bf && time_pulse_three))) begin
				timing_err_ff <= 1'b1;
			end
			// Channel select
			if (common_clear) begin
				channel_select_ff <= 4'h0;
			end else if (op_ld_ch) begin
				channel_select_ff <= data_in[`CHAN_LO+3:`CHAN_LO];
			end else if (eoc_ff && enables_ff[`EN_STEP]) begin
				channel_select_ff <= next_channel;
			end
			// Enable flags only set here; cleared by clear-all
			if (common_clear) begin
				enables_ff <= 4'h0;
			end else if (op_ld_en) begin
				enables_ff <= enables_ff | data_in[`EN_LO+3:`EN_LO];
			end
			irq_ff <= (done_ff && enables_ff[`EN_DONE]) ||
				(timing_err_ff && enables_ff[`EN_ERR]);
			skip_ff <= sel && ((op_code == `OP_SKIP_DONE && done_ff) ||
				(op_code == `OP_SKIP_ERR && timing_err_ff));
			// Readback gating onto data bus
			data_oe_n_ff <= !(op_rd_st || op_rd_bf);
			if (op_rd_st) begin
				data_out_ff <= {channel_select_ff, 2'b00, enables_ff,
					2'b00};
			end else if (op_rd_bf) begin
				data_out_ff <= {result_in[11:2], 2'b00};
			end else begin
				data_out_ff <= 12'h000;
			end
		end
	end
	// Channel register drives the multiplexer directly; holds
endmodule
`default_nettype wire

// ---- logic/adc_ctrl_defines.vh ----
// Constants and behaviour summary for the converter control block
//
// Behaviour
// - Start instruction or gated external start sets busy.
// - Setting busy clears done and starts the bit-timing clock.
// - Clear, init or clear-all at pulse three clear busy and shifter.
// - Channel register selects the multiplexer input being sampled.
// - With auto-step set, channel advances after each conversion.
// - Read-status drives channel on bits 8-11; read-buffer drives result.
// - Load-channel loads any value 0 to 15 from the bus.
// - Next channel is register plus one, loaded at end of conversion.
// - Increment is four bits and wraps fifteen to zero.
// - Common clear zeroes the channel register.
// - Load-enable at pulse three sets flags whose bus bits 2-5 are one.
// - Read-status drives the enable flags onto bus bits 2-5.
// - Read-buffer drives result bits 2-11 onto bus bits 2-11.
// - Done with done-interrupt enabled raises an interrupt request.
// - Sample condition clears mode-select, selecting sample mode.
// - Hold strobe sets mode-select, entering hold mode.
// - Hold interval is about 20 us per conversion.
// - External start acts only when its enable flag is set.
// - Read-buffer, load-channel or external start while busy sets error.
// - Respond only to device code octal 53 during the I/O pause.
// - End-of-conversion clears busy, returning to sample mode.
`ifndef ADC_CTRL_DEFINES_VH
`define ADC_CTRL_DEFINES_VH
`define DEV_CODE 6'h2B
`define OP_SKIP_ERR 3'h0
`define OP_CLEAR_ALL 3'h1
`define OP_LOAD_EN 3'h2
`define OP_READ_STAT 3'h3
`define OP_SKIP_DONE 3'h4
`define OP_LOAD_CHAN 3'h5
`define OP_START 3'h6
`define OP_READ_BUF 3'h7
`define EN_DONE 2'h0
`define EN_ERR 2'h1
`define EN_EXT 2'h2
`define EN_STEP 2'h3
`define CHAN_LO 8
`define EN_LO 2
`define SHIFT_FIRST 10'h200
`define HOLD_NS 20000
`define BIT_NS 1800
`define CLK_NS 8
`endif

// ---- logic/sync3.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 (
	input wire core_clk, // System clock
	input wire rstn, // Synchronous reset, active low
	input wire din, // Asynchronous input
	output reg dout_ff // Filtered level
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	// First stage feeds only the second, avoiding metastable fan-out
	always @(posedge core_clk) begin
		if (!rstn) begin
			s1_ff <= 1'b0;
			s2_ff <= 1'b0;
			s3_ff <= 1'b0;
			dout_ff <= 1'b0;
		end else begin
			s1_ff <= din;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff) begin
				dout_ff <= s3_ff;
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/adc_channel_enable_control_tb.sv ----
// Testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_channel_enable_control_tb;
	logic core_clk = 0;
	logic rstn = 0;
	logic init = 0;
	logic last_shift = 0;
	logic external_conversion_start = 0;
	logic [11:0] result_in = 12'hABF;
	wire io_pause, time_pulse_three, data_oe_n_ff, skip_ff, irq_ff, busy_ff;
	wire done_ff, timing_err_ff, mode_hold_ff, bit_clk_ff, eoc_ff;
	wire [5:0] dev_sel;
	wire [2:0] op_code;
	wire [11:0] data_in, data_out_ff;
	wire [3:0] channel_select_ff, enables_ff;
	wire [9:0] shift_pos_ff;
	logic [11:0] rd;
	int errors = 0;
	int check_count = 0;
	int cycles = 0;
	adc_channel_enable_control #(.HOLD_NS(80), .BIT_NS(40))
		i_adc_channel_enable_control (.*);
	cpu_io_model i_cpu_io_model (.*);
	always #4 core_clk = ~core_clk;
	task summarize;
		$display("errors %0d checks %0d", errors, check_count);
		if (errors == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			errors++;
			summarize();
		end
	end
	task chk(input logic [11:0] got, input logic [11:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task io(input logic [2:0] op, input logic [11:0] acc);
		i_cpu_io_model.io(6'h2B, op, acc, rd);
	endtask
	task step(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task wait_done;
		for (int i = 0; i < 200 && done_ff !== 1'b1; i++)
			step(1);
	endtask
	task ext_pulse;
		external_conversion_start = 1;
		step(8);
		external_conversion_start = 0;
	endtask
	initial begin
		step(16);
		rstn = 1;
		io(3'h3, 12'h000);
		chk(rd, 12'h000);
		io(3'h2, 12'h024);
		io(3'h5, 12'hF00);
		io(3'h3, 12'h000);
		chk(rd, 12'hF24);
		chk(data_oe_n_ff, 1'b0);
		io(3'h6, 12'h000);
		chk(mode_hold_ff, 1);
		step(20);
		last_shift = 1;
		step(1);
		last_shift = 0;
		wait_done;
		chk(busy_ff, 0);
		step(1);
		chk(channel_select_ff, 4'h0);
		chk(irq_ff, 1);
		chk(mode_hold_ff, 0);
		io(3'h4, 12'h000);
		chk(skip_ff, 1);
		io(3'h6, 12'h000);
		chk(done_ff, 0);
		io(3'h5, 12'h700);
		chk(timing_err_ff, 1);
		io(3'h0, 12'h000);
		chk(skip_ff, 1);
		io(3'h7, 12'h000);
		chk(rd, 12'hABC);
		wait_done;
		step(1);
		chk(channel_select_ff, 4'h8);
		i_cpu_io_model.io(6'h2A, 3'h5, 12'h900, rd);
		chk(channel_select_ff, 4'h8);
		io(3'h1, 12'h000);
		chk(channel_select_ff, 4'h0);
		ext_pulse;
		chk(busy_ff, 0);
		io(3'h2, 12'h010);
		ext_pulse;
		chk(busy_ff, 1);
		io(3'h1, 12'h000);
		chk(busy_ff, 0);
		chk(shift_pos_ff, 12'h000);
		summarize();
	end
endmodule
`default_nettype wire

// ---- verif/adc_ctrl_properties.sv ----
// Checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_properties (
	input wire core_clk,
	input wire rstn,
	input wire init,
	input wire io_pause,
	input wire [5:0] dev_sel,
	input wire [2:0] op_code,
	input wire time_pulse_three,
	input wire [11:0] data_in,
	input wire [11:0] result_in,
	input wire [11:0] data_out_ff,
	input wire data_oe_n_ff,
	input wire irq_ff,
	input wire busy_ff,
	input wire done_ff,
	input wire [3:0] channel_select_ff,
	input wire [3:0] enables_ff,
	input wire mode_hold_ff,
	input wire eoc_ff
);
	wire sel = io_pause && dev_sel == 6'h2B;
	wire stb = sel && time_pulse_three;
	wire clr = init || (stb && op_code == 3'h1);
	wire ldch = stb && op_code == 3'h5;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_start_sets_busy: assert property (stb && op_code == 3'h6 && !busy_ff
		&& !clr |=> busy_ff && !done_ff && mode_hold_ff) else $error("no busy");
	a_clear_all_regs: assert property (clr |=> !busy_ff &&
		channel_select_ff == 4'h0 && enables_ff == 4'h0) else $error("no clear");
	a_load_channel: assert property (ldch && !init |=>
		channel_select_ff == $past(data_in[11:8])) else $error("bad load");
	a_auto_step: assert property (eoc_ff && enables_ff[3] && !clr && !ldch
		|=> channel_select_ff == $past(channel_select_ff) + 4'h1)
		else $error("no step");
	a_status_read: assert property (sel && op_code == 3'h3 |=> !data_oe_n_ff
		&& data_out_ff == {$past(channel_select_ff), 2'b00, $past(enables_ff),
		2'b00}) else $error("bad status");
	a_buffer_read: assert property (sel && op_code == 3'h7 |=> !data_oe_n_ff
		&& data_out_ff == {$past(result_in[11:2]), 2'b00}) else $error("bad buf");
	a_done_irq: assert property ($rose(done_ff) && enables_ff[0]
		|-> ##[0:1] irq_ff) else $error("no irq");
	a_end_clears_busy: assert property (eoc_ff |-> done_ff && !busy_ff
		##[0:1] !mode_hold_ff) else $error("bad end");
endmodule
bind adc_channel_enable_control adc_ctrl_properties i_adc_ctrl_properties (.*);
`default_nettype wire

// ---- verif/cpu_io_model.sv ----
// Processor model issuing programmed I/O instructions
`timescale 1ns/1ps
`default_nettype none
module cpu_io_model (
	input wire core_clk, // Clock
	input wire [11:0] data_out_ff, // Device drive value
	output logic io_pause = 1'b0, // I/O pause
	output logic [5:0] dev_sel = 6'h00, // Device field
	output logic [2:0] op_code = 3'h0, // Operation field
	output logic time_pulse_three = 1'b0, // Strobe
	output logic [11:0] data_in = 12'h000 // Accumulator
);
	// Two cycles held, strobe in the first only
	task io(input logic [5:0] dev, input logic [2:0] op,
		input logic [11:0] acc, output logic [11:0] rd);
		@(posedge core_clk);
		#1;
		io_pause = 1'b1;
		dev_sel = dev;
		op_code = op;
		data_in = acc;
		time_pulse_three = 1'b1;
		@(posedge core_clk);
		#1;
		time_pulse_three = 0;
		@(posedge core_clk);
		#1;
		// Read word settles after the edge, while the op is still held
		rd = data_out_ff;
		io_pause = 1'b0;
		// Released field must not look stable
		dev_sel = ~dev_sel;
		data_in = ~data_in;
	endtask
endmodule
`default_nettype wire
